// file: rtl/nvmc_ctrl.sv
// Summary of operation
// - key 0x2 in bits 31:28 unlocks; any other value keeps flash locked
// - system clock divided by 8-bit divisor, reset 0x60, gives operation clock
// - busy flag bit 24 set during operation; only irq register writable then
// - flash access while busy sets the access-violation flag
// - wipe key bits 15:8, 0x55 page, 0xAA mass; cleared after erase
// - bit 4 selects width: 0 programs 128 bits, 1 programs word 0 only
// - bit 25 low-voltage enable, read-write, resets to 1
// - bit 2 starts page erase, reads 1 until erase done
// - bit 1 starts mass erase, cleared by hardware when done
// - bit 0 starts programming, reads 1 while pending or running
// - start bits cannot be cleared by software, only hardware
// - irq bit 9 violation enable, bit 8 completion enable, reset 0
// - program while busy or locked sets violation flag bit 1
// - violation flag set only by hardware; write 0 clears, 1 ignored
// - completion flag bit 0 set after any operation; write 0 clears
// - data words 0..3 form program bits 31:0 up to 127:96, reset zero
// - 32-bit target location register, reset zero, addresses operations
// - irq request when a flag and its enable are both set
// - location bits 3:0 ignored at 128-bit width, 1:0 at 32-bit
// - page erase ignores location bits 12:0
// - mass erase with debug port disabled is refused with violation
`timescale 1ns/100ps
`include "nvmc_params.svh"
module nvmc_ctrl
#(
    parameter int PROG_TICKS = 40,
    parameter int PAGE_TICKS = 20000,
    parameter int MASS_TICKS = 40000
)
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [31:0]  reg_wdata,
    output logic      [31:0]  reg_rdata_q,
    // array access from the core while busy
    input  wire logic         core_access,
    input  wire logic         debug_port_en,
    // flash macro side
    output logic      [31:0]  fl_addr_q,
    output logic      [127:0] fl_data_q,
    output logic              fl_width32_q,
    output logic              fl_prog,
    output logic              fl_page,
    output logic              fl_mass,
    output logic              fl_op_tick,
    output logic              fl_low_volt,
    // interrupt request
    output logic              irq
);
    // register state
    logic [31:0] target_q;
    logic [7:0]  clkdiv_q;
    logic [3:0]  key_q;
    logic        lve_q;
    logic [7:0]  wipe_q;
    logic [2:0]  ctl_rsv_q;
    logic        width_q;
    logic        ctl_b3_q;
    logic        prog_q;
    logic        page_q;
    logic        mass_q;
    logic        viol_ie_q;
    logic        complete_irq_enable_q;
    logic        viol_q;
    logic        done_q;
    logic [31:0] word_q [4];
    logic        start_q;
    nvmc_pkg::nvmc_op_t op_q;

    nvmc_op_if opif ();

    // operation clock divider
    nvmc_tick u_tick
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .div     (clkdiv_q),
        .tick    (fl_op_tick)
    );

    // flash sequencer
    nvmc_engine #(
        .PROG_TICKS (PROG_TICKS),
        .PAGE_TICKS (PAGE_TICKS),
        .MASS_TICKS (MASS_TICKS)
    ) u_eng
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clk_en    (clk_en),
        .tick      (fl_op_tick),
        .opif      (opif.eng),
        .fl_prog_q (fl_prog),
        .fl_page_q (fl_page),
        .fl_mass_q (fl_mass)
    );

    // busy covers the launch cycle and the engine run
    wire busy     = start_q || opif.busy;
    wire wr_en    = clk_en && reg_wr;
    wire wr_irq   = wr_en && (reg_addr == `NVMC_OFS_IRQ);
    wire wr_open  = wr_en && !busy;
    wire wr_ctl   = wr_open && (reg_addr == `NVMC_OFS_CONTROL);
    wire unlocked = (key_q == `NVMC_UNLOCK_KEY);
    wire req_prog = wr_ctl && reg_wdata[`NVMC_CTL_PROG];
    wire req_page = wr_ctl && reg_wdata[`NVMC_CTL_PAGE];
    wire req_mass = wr_ctl && reg_wdata[`NVMC_CTL_MASS];
    wire any_req  = req_prog || req_page || req_mass;
    wire bad_lock = any_req && !unlocked;
    // wipe key must match erase type
    wire bad_key  = (req_page && wipe_q != `NVMC_WIPE_PAGE) ||
                    (req_mass && wipe_q != `NVMC_WIPE_MASS);
    wire bad_dbg  = req_mass && !debug_port_en;
    // access or start attempt while busy
    wire bad_busy = busy && (core_access ||
                    (wr_en && reg_addr == `NVMC_OFS_CONTROL &&
                     (reg_wdata[`NVMC_CTL_PROG] || reg_wdata[`NVMC_CTL_PAGE] ||
                      reg_wdata[`NVMC_CTL_MASS])));
    wire refuse   = bad_lock || bad_key || bad_dbg;
    wire launch   = any_req && !refuse;
    wire viol_set = clk_en && (bad_busy || (any_req && refuse));
    wire done_set = opif.done;

    // width alignment of the program location
    wire [31:0] prog_loc = width_q ? {target_q[31:2], 2'b00} : {target_q[31:4], 4'h0};
    wire [31:0] page_loc = {target_q[31:13], 13'h0};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            target_q <= 32'h0000_0000;
        else if (wr_open && reg_addr == `NVMC_OFS_TARGET)
            target_q <= reg_wdata;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            clkdiv_q <= `NVMC_CLKDIV_RST;
        else if (wr_open && reg_addr == `NVMC_OFS_CLKDIV)
            clkdiv_q <= reg_wdata[7:0];
    end

    // data words, one per generate entry
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_word
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    word_q[gi] <= 32'h0000_0000;
                else if (wr_open && reg_addr == `NVMC_OFS_WORD0 + 8'(4 * gi))
                    word_q[gi] <= reg_wdata;
            end
        end
    endgenerate

    // control plain fields: key, low voltage, width
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            key_q     <= 4'h0;
            lve_q     <= `NVMC_LVE_RST;
            width_q   <= 1'b0;
            ctl_rsv_q <= 3'h0;
            ctl_b3_q  <= 1'b0;
        end
        else if (wr_ctl)
        begin
            key_q     <= reg_wdata[`NVMC_CTL_KEY_HI:`NVMC_CTL_KEY_LO];
            lve_q     <= reg_wdata[`NVMC_CTL_LVE];
            width_q   <= reg_wdata[`NVMC_CTL_WIDTH];
            ctl_rsv_q <= reg_wdata[7:5];
            ctl_b3_q  <= reg_wdata[3];
        end
    end

    // wipe key, cleared when an erase finishes
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            wipe_q <= `NVMC_WIPE_NONE;
        else if (clk_en && done_set && (page_q || mass_q))
            wipe_q <= `NVMC_WIPE_NONE;
        else if (wr_ctl)
            wipe_q <= reg_wdata[`NVMC_CTL_WIPE_HI:`NVMC_CTL_WIPE_LO];
    end

    // start bits set by accepted request, cleared only on completion
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prog_q <= 1'b0;
            page_q <= 1'b0;
            mass_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (done_set)
            begin
                // page erase bit clears on completion
                // mass erase bit clears on completion
                prog_q <= 1'b0;
                page_q <= 1'b0;
                mass_q <= 1'b0;
            end
            else if (launch)
            begin
                prog_q <= req_prog && !req_page && !req_mass;
                page_q <= req_page && !req_mass;
                mass_q <= req_mass;
            end
        end
    end

    // launch pulse, operation select and latched macro inputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            start_q      <= 1'b0;
            op_q         <= nvmc_pkg::NVMC_OP_PROG;
            fl_addr_q    <= 32'h0000_0000;
            fl_data_q    <= 128'h0;
            fl_width32_q <= 1'b0;
        end
        else if (clk_en)
        begin
            start_q <= launch;
            if (launch)
            begin
                op_q         <= req_mass ? nvmc_pkg::NVMC_OP_MASS :
                                req_page ? nvmc_pkg::NVMC_OP_PAGE : nvmc_pkg::NVMC_OP_PROG;
                fl_addr_q    <= (req_page || req_mass) ? page_loc : prog_loc;
                // 32-bit mode takes word 0 only
                fl_data_q    <= width_q ? {96'h0, word_q[0]} :
                                {word_q[3], word_q[2], word_q[1], word_q[0]};
                fl_width32_q <= width_q;
            end
        end
    end

    assign opif.start = start_q;
    assign opif.op    = op_q;

    // irq register: enables writable while busy, flags cleared by write 0
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            viol_ie_q <= 1'b0;
            complete_irq_enable_q <= 1'b0;
            viol_q    <= 1'b0;
            done_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_irq)
            begin
                viol_ie_q <= reg_wdata[`NVMC_IRQ_VIOL_IE];
                complete_irq_enable_q <= reg_wdata[`NVMC_IRQ_COMPLETE_IRQ_ENABLE];
            end
            // set wins, write 0 clears, write 1 ignored
            viol_q <= viol_set || (viol_q && !(wr_irq && !reg_wdata[`NVMC_IRQ_VIOL]));
            done_q <= done_set || (done_q && !(wr_irq && !reg_wdata[`NVMC_IRQ_DONE]));
        end
    end

    assign irq = (viol_q && viol_ie_q) || (done_q && complete_irq_enable_q);

    assign fl_low_volt = lve_q;

    // read mux
    wire [31:0] ctl_rd = {key_q, 2'b00, lve_q, busy, 8'h00, wipe_q,
                          ctl_rsv_q, width_q, ctl_b3_q, page_q, mass_q, prog_q};
    wire [31:0] irq_rd = {22'h0, viol_ie_q, complete_irq_enable_q, 6'h00, viol_q, done_q};
    wire [31:0] rd_mux =
        (reg_addr == `NVMC_OFS_TARGET)  ? target_q :
        (reg_addr == `NVMC_OFS_CLKDIV)  ? {24'h0, clkdiv_q} :
        (reg_addr == `NVMC_OFS_CONTROL) ? ctl_rd :
        (reg_addr == `NVMC_OFS_IRQ)     ? irq_rd :
        (reg_addr == `NVMC_OFS_WORD0)   ? word_q[0] :
        (reg_addr == `NVMC_OFS_WORD1)   ? word_q[1] :
        (reg_addr == `NVMC_OFS_WORD2)   ? word_q[2] :
        (reg_addr == `NVMC_OFS_WORD3)   ? word_q[3] : 32'h0000_0000;

    // registered read data
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            reg_rdata_q <= 32'h0000_0000;
        else if (clk_en && reg_rd)
            reg_rdata_q <= rd_mux;
    end

    // assertions
    AST_BUSY_BLOCKS_TARGET: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && busy && reg_wr && reg_addr == `NVMC_OFS_TARGET |=> $stable(target_q))
        else $error("target changed while busy");
    AST_LOCK_VIOL: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !busy && reg_wr && reg_addr == `NVMC_OFS_CONTROL && reg_wdata[0] &&
        key_q != `NVMC_UNLOCK_KEY |=> viol_q && !start_q)
        else $error("locked program not refused");
    AST_BUSY_ACCESS: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && busy && core_access |=> viol_q)
        else $error("busy access not flagged");
    AST_WIPE_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && opif.done && page_q |=> wipe_q == 8'h00)
        else $error("wipe key not cleared");
    AST_START_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
        prog_q && !(clk_en && opif.done) |=> prog_q)
        else $error("program bit dropped early");
    AST_DONE_SETS: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && opif.done |=> done_q && !prog_q && !page_q && !mass_q)
        else $error("completion not recorded");
    AST_VIOL_W1: assert property (@(posedge clk_sys) disable iff (rst)
        viol_q && clk_en && reg_wr && reg_addr == `NVMC_OFS_IRQ && reg_wdata[1] |=> viol_q)
        else $error("write one cleared violation");
    AST_IRQ_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && done_set && complete_irq_enable_q && !wr_irq |=> irq)
        else $error("irq mismatch");
    AST_MASS_DBG: assert property (@(posedge clk_sys) disable iff (rst)
        clk_en && !busy && reg_wr && reg_addr == `NVMC_OFS_CONTROL && reg_wdata[1] &&
        !debug_port_en |=> !mass_q && viol_q)
        else $error("mass erase without debug port");
    AST_PAGE_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
        fl_page |-> fl_addr_q[12:0] == 13'h0)
        else $error("page address not aligned");
    AST_WIDTH_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
        fl_prog && !fl_width32_q |-> fl_addr_q[3:0] == 4'h0)
        else $error("128-bit address not aligned");
    COV_PROG_DONE: cover property (@(posedge clk_sys) prog_q ##1 !prog_q && done_q);
    COV_PAGE_RUN:  cover property (@(posedge clk_sys) fl_page);
    COV_MASS_RUN:  cover property (@(posedge clk_sys) fl_mass);
    COV_VIOL:      cover property (@(posedge clk_sys) viol_q && irq);
endmodule

// file: common/nvmc_params.svh
`ifndef NVMC_PARAMS_SVH
`define NVMC_PARAMS_SVH
// register byte offsets
`define NVMC_OFS_TARGET   8'h00
`define NVMC_OFS_CLKDIV   8'h04
`define NVMC_OFS_CONTROL  8'h08
`define NVMC_OFS_IRQ      8'h24
`define NVMC_OFS_WORD0    8'h30
`define NVMC_OFS_WORD1    8'h34
`define NVMC_OFS_WORD2    8'h38
`define NVMC_OFS_WORD3    8'h3C
// control field positions
`define NVMC_CTL_KEY_HI   31
`define NVMC_CTL_KEY_LO   28
`define NVMC_CTL_LVE      25
`define NVMC_CTL_BUSY     24
`define NVMC_CTL_WIPE_HI  15
`define NVMC_CTL_WIPE_LO  8
`define NVMC_CTL_WIDTH    4
`define NVMC_CTL_PAGE     2
`define NVMC_CTL_MASS     1
`define NVMC_CTL_PROG     0
// irq field positions
`define NVMC_IRQ_VIOL_IE  9
`define NVMC_IRQ_COMPLETE_IRQ_ENABLE  8
`define NVMC_IRQ_VIOL     1
`define NVMC_IRQ_DONE     0
// key codes and reset values
`define NVMC_UNLOCK_KEY   4'h2
`define NVMC_WIPE_NONE    8'h00
`define NVMC_WIPE_PAGE    8'h55
`define NVMC_WIPE_MASS    8'hAA
`define NVMC_CLKDIV_RST   8'h60
`define NVMC_LVE_RST      1'b1
// timing: operation clock rate
`define NVMC_OPCLK_HZ     1000000
`endif

// file: common/nvmc_pkg.sv
package nvmc_pkg;
    // operation kinds handed to the flash engine
    typedef enum logic [1:0]
    {
        NVMC_OP_PROG = 2'h0,
        NVMC_OP_PAGE = 2'h1,
        NVMC_OP_MASS = 2'h2
    } nvmc_op_t;
endpackage

// file: common/nvmc_op_if.sv
`timescale 1ns/100ps
interface nvmc_op_if;
    logic              start;
    nvmc_pkg::nvmc_op_t op;
    logic              done;
    logic              busy;
    modport ctrl (output start, output op, input done, input busy);
    modport eng  (input start, input op, output done, output busy);
endinterface

// file: rtl/nvmc_tick.sv
`timescale 1ns/100ps
// one-cycle pulse every clkdiv system clocks, the flash operation clock
module nvmc_tick
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // divisor and tick
    input  wire logic [7:0] div,
    output logic            tick
);
    logic [7:0] cnt_q;
    wire        wrap = (cnt_q >= div - 8'h01) || (div == 8'h00);

    // free running divider
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_q <= 8'h00;
        else if (clk_en)
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
    end

    assign tick = clk_en && wrap;
endmodule

// file: rtl/nvmc_engine.sv
`timescale 1ns/100ps
// flash macro sequencer: runs one operation for a number of operation ticks
module nvmc_engine
#(
    parameter int PROG_TICKS = 40,
    parameter int PAGE_TICKS = 20000,
    parameter int MASS_TICKS = 40000
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic tick,
    // operation handshake
    nvmc_op_if.eng    opif,
    // flash macro strobes
    output logic      fl_prog_q,
    output logic      fl_page_q,
    output logic      fl_mass_q
);
    typedef enum logic [1:0] { ENG_IDLE = 2'b01, ENG_RUN = 2'b10 } nvmc_eng_t;
    nvmc_eng_t   st_q;
    logic [31:0] left_q;

    wire [31:0] len = (opif.op == nvmc_pkg::NVMC_OP_PROG) ? 32'(PROG_TICKS) :
                      (opif.op == nvmc_pkg::NVMC_OP_PAGE) ? 32'(PAGE_TICKS) :
                      32'(MASS_TICKS);
    wire        fin = (st_q == ENG_RUN) && tick && (left_q <= 32'h1);

    // state and tick counter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q      <= ENG_IDLE;
            left_q    <= 32'h0;
            fl_prog_q <= 1'b0;
            fl_page_q <= 1'b0;
            fl_mass_q <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (st_q)
                ENG_IDLE:
                    if (opif.start)
                    begin
                        st_q      <= ENG_RUN;
                        left_q    <= len;
                        fl_prog_q <= (opif.op == nvmc_pkg::NVMC_OP_PROG);
                        fl_page_q <= (opif.op == nvmc_pkg::NVMC_OP_PAGE);
                        fl_mass_q <= (opif.op == nvmc_pkg::NVMC_OP_MASS);
                    end
                ENG_RUN:
                    if (fin)
                    begin
                        st_q      <= ENG_IDLE;
                        fl_prog_q <= 1'b0;
                        fl_page_q <= 1'b0;
                        fl_mass_q <= 1'b0;
                    end
                    else if (tick)
                        left_q <= left_q - 32'h1;
            endcase
        end
    end

    assign opif.done = clk_en && fin;
    assign opif.busy = (st_q == ENG_RUN);
endmodule

// file: verification/nvmc_flash_model.sv
`timescale 1ns/100ps
// flash macro stand-in: records each operation it is handed
module nvmc_flash_model
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // macro strobes and operands
    input  wire logic         fl_prog,
    input  wire logic         fl_page,
    input  wire logic         fl_mass,
    input  wire logic [31:0]  fl_addr_q,
    input  wire logic [127:0] fl_data_q,
    // captured view for the bench
    output logic      [1:0]   kind_q,
    output logic      [31:0]  addr_q,
    output logic      [127:0] data_q,
    output logic      [7:0]   count_q
);
    logic [2:0] seen_q;
    wire  [2:0] strobe = {fl_mass, fl_page, fl_prog};
    wire  [2:0] rise   = strobe & ~seen_q;
    // latch operands on the first cycle of each strobe
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            seen_q <= 3'h0;
            kind_q <= 2'h3;
            addr_q <= 32'h0;
            data_q <= 128'h0;
            count_q <= 8'h0;
        end
        else
        begin
            seen_q <= strobe;
            if (rise != 3'h0)
            begin
                kind_q <= rise[2] ? 2'h2 : (rise[1] ? 2'h1 : 2'h0);
                addr_q <= fl_addr_q;
                data_q <= fl_data_q;
                count_q <= count_q + 8'h1;
            end
        end
    end
endmodule

// file: verification/flash_program_erase_ctrl_bench.sv
`timescale 1ns/100ps
`include "nvmc_params.svh"
module flash_program_erase_ctrl_bench;
    logic         clk_sys, rst, reg_wr, reg_rd, core_access, debug_port_en, clk_en;
    logic [7:0]   reg_addr;
    logic [31:0]  reg_wdata, reg_rdata_q, fl_addr_q, m_addr;
    logic [127:0] fl_data_q, m_data, wexp;
    logic         fl_width32_q, fl_prog, fl_page, fl_mass, fl_op_tick, fl_low_volt, irq;
    logic [1:0]   m_kind;
    logic [7:0]   m_count;
    int           miscompares = 0;
    int           samples_checked = 0;

    nvmc_ctrl #(.PROG_TICKS(4), .PAGE_TICKS(5), .MASS_TICKS(6)) i_dut
    (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .core_access(core_access),
        .debug_port_en(debug_port_en), .fl_addr_q(fl_addr_q), .fl_data_q(fl_data_q),
        .fl_width32_q(fl_width32_q), .fl_prog(fl_prog), .fl_page(fl_page),
        .fl_mass(fl_mass), .fl_op_tick(fl_op_tick), .fl_low_volt(fl_low_volt), .irq(irq)
    );
    nvmc_flash_model i_flash
    (
        .clk_sys(clk_sys), .rst(rst), .fl_prog(fl_prog), .fl_page(fl_page),
        .fl_mass(fl_mass), .fl_addr_q(fl_addr_q), .fl_data_q(fl_data_q),
        .kind_q(m_kind), .addr_q(m_addr), .data_q(m_data), .count_q(m_count)
    );

    // compare and count
    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
        // idle edge so the next write never retoggles the strobe in one step
        @(posedge clk_sys);
        #1;
    endtask
    // register read and compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
        @(posedge clk_sys);
        #1 chk(name, exp, reg_rdata_q);
    endtask
    // poll the flash strobes under a bounded count
    task automatic wait_idle;
        int n;
        for (n = 0; n < 60; n++)
        begin
            @(posedge clk_sys);
            #1 if (i_flash.strobe === 3'h0 && n > 2) break;
        end
        repeat (3) @(posedge clk_sys);
        #1 chk("operation finished", 3'h0, i_flash.strobe);
    endtask
    // closing verdict
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic t_reset;
        int n;
        rdchk(`NVMC_OFS_TARGET, 32'h0, "target reset");
        rdchk(`NVMC_OFS_CLKDIV, 32'h00000060, "divisor reset");
        rdchk(`NVMC_OFS_CONTROL, 32'h02000000, "control reset");
        chk("low volt reset", 1'b1, fl_low_volt);
        wr(`NVMC_OFS_CONTROL, 32'h0);
        chk("low volt off", 1'b0, fl_low_volt);
        wr(`NVMC_OFS_CONTROL, 32'h02000000);
        chk("low volt on", 1'b1, fl_low_volt);
        rdchk(`NVMC_OFS_IRQ, 32'h0, "irq reset");
        for (n = 0; n < 4; n++)
            rdchk(`NVMC_OFS_WORD0 + 8'(4 * n), 32'h0, "word reset");
        rdchk(8'h10, 32'h0, "unmapped read");
        clk_en = 1'b0;
        wr(`NVMC_OFS_TARGET, 32'h0000005A);
        clk_en = 1'b1;
        rdchk(`NVMC_OFS_TARGET, 32'h0, "frozen write");
        wr(`NVMC_OFS_CLKDIV, 32'h00000004);
        n = 0;
        while (fl_op_tick !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        while (fl_op_tick !== 1'b1 && n < 20);
        chk("tick period", 4, n);
    endtask

    task automatic t_locked;
        wr(`NVMC_OFS_CONTROL, 32'h32000000);
        wr(`NVMC_OFS_CONTROL, 32'h32000001);
        rdchk(`NVMC_OFS_CONTROL, 32'h32000000, "locked no start");
        rdchk(`NVMC_OFS_IRQ, 32'h00000002, "locked violation");
        wr(`NVMC_OFS_IRQ, 32'h00000202);
        rdchk(`NVMC_OFS_IRQ, 32'h00000202, "flag write one");
        chk("irq on violation", 1'b1, irq);
        wr(`NVMC_OFS_IRQ, 32'h0);
        rdchk(`NVMC_OFS_IRQ, 32'h0, "flag write zero");
        chk("macro idle", 8'h0, m_count);
    endtask

    task automatic t_prog;
        int n;
        for (n = 0; n < 4; n++)
            wr(`NVMC_OFS_WORD0 + 8'(4 * n), 32'hC0DE0000 | n);
        wr(`NVMC_OFS_TARGET, 32'h0000123F);
        wr(`NVMC_OFS_CONTROL, 32'h22000000);
        wr(`NVMC_OFS_CONTROL, 32'h22000001);
        rdchk(`NVMC_OFS_CONTROL, 32'h23000001, "program busy");
        wr(`NVMC_OFS_CONTROL, 32'h22000000);
        wr(`NVMC_OFS_TARGET, 32'h0);
        core_access = 1'b1;
        @(posedge clk_sys);
        #1 core_access = 1'b0;
        rdchk(`NVMC_OFS_CONTROL, 32'h23000001, "start kept");
        wait_idle();
        rdchk(`NVMC_OFS_TARGET, 32'h0000123F, "target kept");
        chk("addr 128", 32'h00001230, m_addr);
        wexp = 128'hC0DE0003_C0DE0002_C0DE0001_C0DE0000;
        chk("data 128", wexp, m_data);
        rdchk(`NVMC_OFS_IRQ, 32'h00000003, "done and busy access");
        wr(`NVMC_OFS_IRQ, 32'h0);
        wr(`NVMC_OFS_CONTROL, 32'h22000010);
        wr(`NVMC_OFS_CONTROL, 32'h22000011);
        wait_idle();
        rdchk(`NVMC_OFS_CONTROL, 32'h22000010, "program cleared");
        chk("addr 32", 32'h0000123C, m_addr);
        chk("data 32", 128'hC0DE0000, m_data);
        chk("width flag", 1'b1, fl_width32_q);
        chk("op count", {2'h0, 8'h2}, {m_kind, m_count});
        wr(`NVMC_OFS_IRQ, 32'h0);
    endtask

    task automatic t_page;
        wr(`NVMC_OFS_TARGET, 32'h0000BEEF);
        wr(`NVMC_OFS_CONTROL, 32'h2200AA00);
        wr(`NVMC_OFS_CONTROL, 32'h2200AA04);
        rdchk(`NVMC_OFS_IRQ, 32'h00000002, "wrong wipe key");
        wr(`NVMC_OFS_IRQ, 32'h0);
        wr(`NVMC_OFS_CONTROL, 32'h22005500);
        wr(`NVMC_OFS_CONTROL, 32'h22005504);
        rdchk(`NVMC_OFS_CONTROL, 32'h23005504, "page busy");
        wait_idle();
        rdchk(`NVMC_OFS_CONTROL, 32'h22000000, "page cleared");
        chk("page addr", 32'h0000A000, m_addr);
        chk("page count", {2'h1, 8'h3}, {m_kind, m_count});
        rdchk(`NVMC_OFS_IRQ, 32'h00000001, "page done");
        wr(`NVMC_OFS_IRQ, 32'h0);
    endtask

    task automatic t_mass;
        debug_port_en = 1'b0;
        wr(`NVMC_OFS_CONTROL, 32'h2200AA00);
        wr(`NVMC_OFS_CONTROL, 32'h2200AA02);
        rdchk(`NVMC_OFS_IRQ, 32'h00000002, "debug off");
        wr(`NVMC_OFS_IRQ, 32'h00000100);
        debug_port_en = 1'b1;
        wr(`NVMC_OFS_CONTROL, 32'h2200AA00);
        wr(`NVMC_OFS_CONTROL, 32'h2200AA02);
        rdchk(`NVMC_OFS_CONTROL, 32'h2300AA02, "mass busy");
        wait_idle();
        rdchk(`NVMC_OFS_CONTROL, 32'h22000000, "mass cleared");
        chk("mass count", {2'h2, 8'h4}, {m_kind, m_count});
        chk("irq on done", 1'b1, irq);
        rdchk(`NVMC_OFS_IRQ, 32'h00000101, "mass done");
        wr(`NVMC_OFS_IRQ, 32'h0);
        chk("irq cleared", 1'b0, irq);
    endtask

    // system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        test_done();
    end
    // main sequence
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        core_access = 1'b0;
        debug_port_en = 1'b1;
        clk_en = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset();
        t_locked();
        t_prog();
        t_page();
        t_mass();
        test_done();
    end
endmodule
